//--- pss_pkg.sv
package pss_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SWP1 = 8'h04;
	localparam logic [7:0] REG_SWP2 = 8'h08;
	localparam logic [7:0] REG_SPDSET = 8'h0c;
	localparam logic [7:0] REG_STBY = 8'h10;
	localparam logic [7:0] REG_NOMSPD = 8'h14;
	localparam logic [7:0] REG_BPON = 8'h18;
	localparam logic [7:0] REG_BPOFF = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_IRQ_STAT = 8'h24;
	localparam logic [7:0] REG_IRQ_EN = 8'h28;
	localparam logic [7:0] REG_IRQ_CLR = 8'h2c;
	localparam logic [7:0] REG_MEAS = 8'h30;

	// ==========================================================
	// Control register fields
	localparam int CTRL_STATION = 0;
	localparam int CTRL_MOTOR_EN = 1;
	localparam int CTRL_SWP_CFG = 2;
	localparam int CTRL_SPDSET_EN = 3;
	localparam int CTRL_STBY_EN = 4;
	localparam int CTRL_BP_MODE_LSB = 5;

	// ==========================================================
	// Reset values (switch points and set speeds in tenths of a percent, speeds in Hz)
	localparam logic [9:0] SWP1_RST = 10'h320;
	localparam logic [9:0] SWP2_RST = 10'h320;
	localparam logic [9:0] SPDSET_RST = 10'h3e8;
	localparam logic [9:0] STBY_RST = 10'h29b;
	localparam logic [15:0] NOM_HI = 16'h03e8;
	localparam logic [15:0] NOM_LO = 16'h0334;
	localparam logic [15:0] BP_ON_RST = 16'h0000;
	localparam logic [15:0] BP_OFF_RST = 16'h0000;
	localparam logic [9:0] FULL_PERMILLE = 10'h3e8;
	localparam logic [15:0] DELAY_ON_HZ = 16'h0006;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 20000000;
	localparam int UPDATE_US = 100;
	localparam int UPDATE_CYC = CLK_HZ / 1000000 * UPDATE_US;
	localparam int SELFTEST_US = 10;
	localparam int SELFTEST_CYC = CLK_HZ / 1000000 * SELFTEST_US;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		BP_CONT = 2'h0,
		BP_INTER = 2'h1,
		BP_DELAY = 2'h2
	} pss_bp_mode_t;

	typedef enum {
		ST_OFF,
		ST_CLEAR,
		ST_TEST,
		ST_RUN
	} pss_seq_t;

	typedef struct packed {
		logic station;
		logic motor_en;
		logic swp_cfg;
		logic spdset_en;
		logic stby_en;
		logic [1:0] bp_mode;
	} pss_ctrl_t;

	typedef struct packed {
		logic speed_reached;
		logic set_speed_attained_flag;
		logic backing_pump;
		logic motor_on;
		logic accessories_on;
		logic vent_req;
		logic error_clear;
	} pss_out_t;

endpackage

//--- pss_supervisor.sv
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pss_supervisor #(
	parameter int UPDATE_CYCLES = pss_pkg::UPDATE_CYC,
	parameter int SELFTEST_CYCLES = pss_pkg::SELFTEST_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [15:0] speed_hz,
	input wire logic [15:0] drive_power,
	input wire logic selftest_ok,
	output logic speed_reached,
	output logic set_speed_attained_flag,
	output logic backing_pump,
	output logic motor_on,
	output logic accessories_on,
	output logic vent_req,
	output logic error_clear,
	output logic set_speed_valid,
	output logic [15:0] set_speed_hz,
	output logic irq
);

	// ==========================================================
	// State
	typedef struct packed {
		pss_pkg::pss_ctrl_t ctrl;
		logic [9:0] swp1;
		logic [9:0] swp2;
		logic [9:0] spdset;
		logic [9:0] stby;
		logic [15:0] nom;
		logic [15:0] bp_on;
		logic [15:0] bp_off;
		pss_pkg::pss_seq_t seq;
		logic [15:0] tick_cnt;
		logic [15:0] test_cnt;
		logic tick;
		logic inter_on;
		logic [15:0] spd_s;
		logic [15:0] pwr_s;
		logic [15:0] set_hz;
		pss_pkg::pss_out_t out;
		logic [3:0] irq_stat;
		logic [3:0] irq_en;
		logic [31:0] rdata;
		logic [2:0] st_sync;
	} pss_state_t;

	pss_state_t s_reg;
	pss_state_t s_next;

	// Percent-of-nominal (tenths) to Hz
	function automatic logic [15:0] pct_hz(input logic [15:0] nom, input logic [9:0] pm);
		logic [25:0] p;
		p = nom * pm;
		return 16'(p / 26'(pss_pkg::FULL_PERMILLE));
	endfunction

	logic [15:0] swp_hz;
	logic [15:0] swp1_hz;
	logic [15:0] swp2_hz;
	logic [15:0] hi_hz;
	logic [15:0] lo_hz;
	logic [3:0] ev;
	logic reduced;
	logic [9:0] set_pm;

	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		s_next.out.error_clear = 1'b0;
		s_next.st_sync = {s_reg.st_sync[1:0], selftest_ok};
		ev = 4'h0;
		// ==========================================================
		// Register writes
		if (wr) begin
			unique case (addr)
				pss_pkg::REG_CTRL: begin
					s_next.ctrl.station = wdata[pss_pkg::CTRL_STATION];
					s_next.ctrl.motor_en = wdata[pss_pkg::CTRL_MOTOR_EN];
					s_next.ctrl.swp_cfg = wdata[pss_pkg::CTRL_SWP_CFG];
					s_next.ctrl.spdset_en = wdata[pss_pkg::CTRL_SPDSET_EN];
					s_next.ctrl.stby_en = wdata[pss_pkg::CTRL_STBY_EN];
					s_next.ctrl.bp_mode = wdata[pss_pkg::CTRL_BP_MODE_LSB +: 2];
				end
				pss_pkg::REG_SWP1: s_next.swp1 = wdata[9:0];
				pss_pkg::REG_SWP2: s_next.swp2 = wdata[9:0];
				pss_pkg::REG_SPDSET: s_next.spdset = wdata[9:0];
				pss_pkg::REG_STBY: s_next.stby = wdata[9:0];
				pss_pkg::REG_NOMSPD: s_next.nom = wdata[15:0];
				pss_pkg::REG_BPON: s_next.bp_on = wdata[15:0];
				pss_pkg::REG_BPOFF: s_next.bp_off = wdata[15:0];
				pss_pkg::REG_IRQ_EN: s_next.irq_en = wdata[3:0];
				default: ;
			endcase
		end
		// ==========================================================
		// Update tick
		// periodic compare tick
		if (s_reg.tick_cnt == 16'(UPDATE_CYCLES - 1)) begin
			s_next.tick_cnt = 16'h0000;
			s_next.tick = 1'b1;
			s_next.spd_s = speed_hz;
			s_next.pwr_s = drive_power;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
		end
		// ==========================================================
		// Set speed selection
		// speed-setting beats standby
		reduced = s_reg.ctrl.spdset_en | s_reg.ctrl.stby_en;
		set_pm = s_reg.ctrl.spdset_en ? s_reg.spdset :
			(s_reg.ctrl.stby_en ? s_reg.stby : pss_pkg::FULL_PERMILLE);
		s_next.set_hz = pct_hz(s_reg.nom, set_pm);
		// switch points scale with set speed in speed-setting mode, with nominal speed otherwise
		swp1_hz = pct_hz(s_reg.ctrl.spdset_en ? s_reg.set_hz : s_reg.nom, s_reg.swp1);
		swp2_hz = pct_hz(s_reg.ctrl.spdset_en ? s_reg.set_hz : s_reg.nom, s_reg.swp2);
		hi_hz = (swp1_hz > swp2_hz) ? swp1_hz : swp2_hz;
		lo_hz = (swp1_hz > swp2_hz) ? swp2_hz : swp1_hz;
		swp_hz = (s_reg.ctrl.swp_cfg && !s_reg.ctrl.station) ? swp2_hz : swp1_hz;
		if (s_reg.tick) begin
			if (!s_reg.ctrl.swp_cfg || !s_reg.ctrl.station) begin
				s_next.out.speed_reached = s_reg.spd_s >= swp_hz;
			end else if (s_reg.spd_s >= hi_hz) begin
				s_next.out.speed_reached = 1'b1;
			end else if (s_reg.spd_s < lo_hz) begin
				s_next.out.speed_reached = 1'b0;
			end
			if (reduced && s_reg.spd_s < s_reg.set_hz) begin
				s_next.out.set_speed_attained_flag = 1'b1;
			end else if (!reduced || s_reg.spd_s > s_reg.set_hz) begin
				s_next.out.set_speed_attained_flag = 1'b0;
			end
			if (s_reg.pwr_s > s_reg.bp_on) begin
				s_next.inter_on = 1'b1;
			end else if (s_reg.pwr_s < s_reg.bp_off) begin
				s_next.inter_on = 1'b0;
			end
		end
		// ==========================================================
		// Station sequence
		unique case (s_reg.seq)
			pss_pkg::ST_OFF: begin
				if (s_reg.ctrl.station) begin
					s_next.seq = pss_pkg::ST_CLEAR;
					s_next.out.error_clear = 1'b1;
					s_next.out.vent_req = 1'b0;
				end
			end
			pss_pkg::ST_CLEAR: begin
				s_next.seq = pss_pkg::ST_TEST;
				s_next.test_cnt = 16'h0000;
			end
			pss_pkg::ST_TEST: begin
				if (!s_reg.ctrl.station) begin
					s_next.seq = pss_pkg::ST_OFF;
				end else if (s_reg.test_cnt >= 16'(SELFTEST_CYCLES - 1)
					&& s_reg.st_sync[2] && s_reg.st_sync[1]) begin
					s_next.seq = pss_pkg::ST_RUN;
					s_next.out.accessories_on = 1'b1;
					ev[2] = 1'b1;
				end else if (s_reg.test_cnt != 16'hffff) begin
					s_next.test_cnt = s_reg.test_cnt + 16'h0001;
				end
			end
			pss_pkg::ST_RUN: begin
				if (!s_reg.ctrl.station) begin
					s_next.seq = pss_pkg::ST_OFF;
					s_next.out.accessories_on = 1'b0;
					s_next.out.vent_req = 1'b1;
					ev[3] = 1'b1;
				end
			end
		endcase
		s_next.out.motor_on = (s_next.seq == pss_pkg::ST_RUN) && s_reg.ctrl.motor_en;
		// ==========================================================
		// Backing pump
		// mode decode
		unique case (s_reg.ctrl.bp_mode)
			pss_pkg::BP_CONT: s_next.out.backing_pump = s_reg.seq == pss_pkg::ST_RUN;
			pss_pkg::BP_INTER: s_next.out.backing_pump =
				(s_reg.seq == pss_pkg::ST_RUN) && s_reg.inter_on;
			pss_pkg::BP_DELAY: s_next.out.backing_pump =
				(s_reg.seq == pss_pkg::ST_RUN) && (s_reg.spd_s >= pss_pkg::DELAY_ON_HZ);
			default: s_next.out.backing_pump = 1'b0;
		endcase
		// ==========================================================
		// Interrupts, set wins over clear
		ev[0] = s_next.out.speed_reached != s_reg.out.speed_reached;
		ev[1] = s_next.out.set_speed_attained_flag != s_reg.out.set_speed_attained_flag;
		if (wr && addr == pss_pkg::REG_IRQ_CLR) begin
			s_next.irq_stat = s_reg.irq_stat & ~wdata[3:0];
		end
		s_next.irq_stat = s_next.irq_stat | ev;
		// ==========================================================
		// Read data
		s_next.rdata = 32'h0000_0000;
		if (rd) begin
			unique case (addr)
				pss_pkg::REG_CTRL: s_next.rdata = 32'({s_reg.ctrl.bp_mode, s_reg.ctrl.stby_en,
					s_reg.ctrl.spdset_en, s_reg.ctrl.swp_cfg, s_reg.ctrl.motor_en,
					s_reg.ctrl.station});
				pss_pkg::REG_SWP1: s_next.rdata = 32'(s_reg.swp1);
				pss_pkg::REG_SWP2: s_next.rdata = 32'(s_reg.swp2);
				pss_pkg::REG_SPDSET: s_next.rdata = 32'(s_reg.spdset);
				pss_pkg::REG_STBY: s_next.rdata = 32'(s_reg.stby);
				pss_pkg::REG_NOMSPD: s_next.rdata = 32'(s_reg.nom);
				pss_pkg::REG_BPON: s_next.rdata = 32'(s_reg.bp_on);
				pss_pkg::REG_BPOFF: s_next.rdata = 32'(s_reg.bp_off);
				pss_pkg::REG_STATUS: s_next.rdata = 32'({s_reg.set_hz, 9'h000,
					s_reg.out});
				pss_pkg::REG_IRQ_STAT: s_next.rdata = 32'(s_reg.irq_stat);
				pss_pkg::REG_IRQ_EN: s_next.rdata = 32'(s_reg.irq_en);
				pss_pkg::REG_MEAS: s_next.rdata = {s_reg.pwr_s, s_reg.spd_s};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.swp1 <= pss_pkg::SWP1_RST;
			s_reg.swp2 <= pss_pkg::SWP2_RST;
			s_reg.spdset <= pss_pkg::SPDSET_RST;
			s_reg.stby <= pss_pkg::STBY_RST;
			s_reg.nom <= pss_pkg::NOM_HI;
			s_reg.bp_on <= pss_pkg::BP_ON_RST;
			s_reg.bp_off <= pss_pkg::BP_OFF_RST;
			s_reg.seq <= pss_pkg::ST_OFF;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs
	assign rdata = s_reg.rdata;
	assign speed_reached = s_reg.out.speed_reached;
	assign set_speed_attained_flag = s_reg.out.set_speed_attained_flag;
	assign backing_pump = s_reg.out.backing_pump;
	assign motor_on = s_reg.out.motor_on;
	assign accessories_on = s_reg.out.accessories_on;
	assign vent_req = s_reg.out.vent_req;
	assign error_clear = s_reg.out.error_clear;
	assign set_speed_valid = s_reg.ctrl.spdset_en | s_reg.ctrl.stby_en;
	assign set_speed_hz = s_reg.set_hz;
	assign irq = |(s_reg.irq_stat & s_reg.irq_en);

endmodule

`default_nettype wire

//--- pss_supervisor_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pss_supervisor_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic speed_reached,
	input wire logic set_speed_attained_flag,
	input wire logic backing_pump,
	input wire logic motor_on,
	input wire logic accessories_on,
	input wire logic vent_req,
	input wire logic error_clear,
	input wire logic set_speed_valid,
	input wire logic [15:0] set_speed_hz
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_held_off;
		(!motor_on && !accessories_on) [*3];
	endsequence
	sequence s_status_seen;
		rdata[31:16] == $past(set_speed_hz) && rdata[6] == $past(speed_reached)
			&& rdata[2] == $past(accessories_on);
	endsequence
	// ==========================================================
	// Checks
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero outside read answer");
	status_read_a: assert property (rd && addr == 8'h20 |=> s_status_seen)
		else $error("status read does not match outputs");
	clear_pulse_a: assert property (error_clear |=> !error_clear)
		else $error("error clear longer than one cycle");
	selftest_wait_a: assert property (error_clear |-> s_held_off)
		else $error("motor started before self-test");
	motor_vent_a: assert property (motor_on |-> !vent_req)
		else $error("motor on while venting requested");
	motor_start_a: assert property ($rose(motor_on) |-> accessories_on)
		else $error("motor started outside running station");
	flag_clear_a: assert property (!set_speed_valid |-> ##[0:12] !set_speed_attained_flag)
		else $error("attained flag kept without reduced mode");
	backing_off_a: assert property ($rose(vent_req) |-> ##[0:12] !backing_pump)
		else $error("backing pump kept after station off");
endmodule
bind pss_supervisor pss_supervisor_monitor u_mon (.clk, .rst_n, .addr, .rd, .rdata,
	.speed_reached, .set_speed_attained_flag, .backing_pump, .motor_on, .accessories_on,
	.vent_req, .error_clear, .set_speed_valid, .set_speed_hz);
`default_nettype wire

//--- pss_pump_model.sv
`timescale 1ns/1ps
`default_nettype none
module pss_pump_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic motor_on,
	input wire logic [15:0] target_hz,
	output logic [15:0] speed_hz,
	output logic selftest_ok
);
	logic [15:0] goal;
	// Rotor ramps 50 Hz a cycle, coasts down when the motor stops
	assign goal = motor_on ? target_hz : 16'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_hz <= 16'h0;
			selftest_ok <= 1'b0;
		end else begin
			selftest_ok <= 1'b1;
			if (speed_hz + 16'h32 < goal) begin
				speed_hz <= speed_hz + 16'h32;
			end else if (speed_hz > goal + 16'h32) begin
				speed_hz <= speed_hz - 16'h32;
			end else begin
				speed_hz <= goal;
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst_n, wr, rd, selftest_ok, sr, ssa, bp, mot, acc, vent, ec, ssv, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [15:0] speed_hz, power, target, shz;
	int error_cnt, n_compared, ec_cnt;
	logic [15:0] dual_hz[4] = '{16'h352, 16'h28a, 16'h1c2, 16'h28a};
	logic dual_sr[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	logic [15:0] pw[3] = '{16'h78, 16'h46, 16'h1e};
	logic pw_bp[3] = '{1'b1, 1'b1, 1'b0};
	pss_supervisor #(.UPDATE_CYCLES(4), .SELFTEST_CYCLES(2)) uut (.clk(clk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .speed_hz(speed_hz),
		.drive_power(power), .selftest_ok(selftest_ok), .speed_reached(sr),
		.set_speed_attained_flag(ssa), .backing_pump(bp), .motor_on(mot),
		.accessories_on(acc), .vent_req(vent), .error_clear(ec), .set_speed_valid(ssv),
		.set_speed_hz(shz), .irq(irq));
	pss_pump_model pump (.clk(clk), .rst_n(rst_n), .motor_on(mot), .target_hz(target),
		.speed_hz(speed_hz), .selftest_ok(selftest_ok));
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		chk(32'(shz), 32'h3e8);
		rchk(pss_pkg::REG_SWP1, 32'h320);
		rchk(pss_pkg::REG_STBY, 32'h29b);
		rchk(pss_pkg::REG_NOMSPD, 32'h3e8);
		rchk(8'h3c, 32'h0);
	endtask
	task automatic t_start();
		target = 16'h258;
		wreg(pss_pkg::REG_CTRL, 32'h03);
		wt(80);
		chk(ec_cnt, 1);
		chk({mot, acc, bp, sr}, 4'he);
		rchk(pss_pkg::REG_STATUS, 32'h03e8_001c);
		rchk(pss_pkg::REG_MEAS, 32'h0000_0258);
		target = 16'h352;
		wt(80);
		chk(32'(sr), 32'h1);
		wreg(pss_pkg::REG_CTRL, 32'h01);
		wt(80);
		chk({mot, acc}, 2'h1);
		wreg(pss_pkg::REG_CTRL, 32'h03);
		wt(80);
		chk(32'(mot), 32'h1);
	endtask
	task automatic t_dual();
		wreg(pss_pkg::REG_SWP2, 32'h1f4);
		wreg(pss_pkg::REG_CTRL, 32'h07);
		foreach (dual_hz[i]) begin
			target = dual_hz[i];
			wt(80);
			chk(32'(sr), 32'(dual_sr[i]));
		end
		wreg(pss_pkg::REG_IRQ_CLR, 32'hf);
		wreg(pss_pkg::REG_CTRL, 32'h06);
		wt(80);
		rchk(pss_pkg::REG_IRQ_STAT, 32'h9);
	endtask
	task automatic t_reduced();
		wreg(pss_pkg::REG_SPDSET, 32'h1f4);
		wreg(pss_pkg::REG_CTRL, 32'h1b);
		target = 16'h1c2;
		wt(80);
		chk({ssv, shz}, {1'b1, 16'h1f4});
		chk({ssa, sr}, 2'h3);
		target = 16'h226;
		wt(80);
		chk(32'(ssa), 32'h0);
		wreg(pss_pkg::REG_NOMSPD, 32'h334);
		wt(20);
		chk(32'(shz), 32'h19a);
		wreg(pss_pkg::REG_NOMSPD, 32'h3e8);
		wreg(pss_pkg::REG_CTRL, 32'h13);
		target = 16'h258;
		wt(80);
		chk({ssa, shz}, {1'b1, 16'h29b});
		target = 16'h2bc;
		wt(80);
		chk(32'(ssa), 32'h0);
	endtask
	task automatic t_backing();
		wreg(pss_pkg::REG_BPON, 32'h64);
		wreg(pss_pkg::REG_BPOFF, 32'h32);
		wreg(pss_pkg::REG_CTRL, 32'h23);
		wt(40);
		chk(32'(bp), 32'h0);
		foreach (pw[i]) begin
			@(posedge clk);
			power <= pw[i];
			wt(40);
			chk(32'(bp), 32'(pw_bp[i]));
		end
		wreg(pss_pkg::REG_CTRL, 32'h43);
		target = 16'h5;
		wt(80);
		chk(32'(bp), 32'h0);
		target = 16'h6;
		wt(40);
		chk(32'(bp), 32'h1);
		wreg(pss_pkg::REG_CTRL, 32'h63);
		wt(3);
		chk(32'(bp), 32'h0);
	endtask
	task automatic t_off();
		wreg(pss_pkg::REG_IRQ_CLR, 32'hf);
		wreg(pss_pkg::REG_IRQ_EN, 32'h8);
		wreg(pss_pkg::REG_CTRL, 32'h02);
		wt(20);
		chk({mot, vent, irq}, 3'h3);
		wreg(pss_pkg::REG_IRQ_EN, 32'h0);
		wt(3);
		chk(32'(irq), 32'h0);
		wreg(pss_pkg::REG_IRQ_EN, 32'h8);
		wreg(pss_pkg::REG_IRQ_CLR, 32'hf);
		wt(3);
		chk(32'(irq), 32'h0);
	endtask
	// ==========================================================
	// Clock, main sequence
	always @(posedge clk) if (ec === 1'b1) ec_cnt++;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
	initial begin
		{rst_n, wr, rd, addr, wdata, power, target} = '0;
		error_cnt = 0;
		n_compared = 0;
		ec_cnt = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		wt(2);
		t_regs();
		t_start();
		t_dual();
		t_reduced();
		t_backing();
		t_off();
		complete_run();
	end
endmodule
`default_nettype wire
